/* prci_pkg.sv */
package prci_pkg;

  // Register byte offsets
  localparam logic [7:0] PRCI_OFF_CTRL = 8'h00;
  localparam logic [7:0] PRCI_OFF_INTX = 8'h04;
  localparam logic [7:0] PRCI_OFF_STAT = 8'h08;
  localparam logic [7:0] PRCI_OFF_ACSV = 8'h0C;
  localparam logic [7:0] PRCI_OFF_SPIB = 8'h10;
  localparam logic [7:0] PRCI_OFF_MEMW = 8'h14;
  localparam logic [7:0] PRCI_OFF_TUID = 8'h18;
  localparam logic [7:0] PRCI_OFF_PTM = 8'h1C;

  // Control fields
  localparam int PRCI_CTRL_XLAT = 0;
  localparam int PRCI_CTRL_NSDG = 1;
  localparam int PRCI_CTRL_P2P = 2;
  localparam int PRCI_CTRL_ACS_EN = 3;
  localparam int PRCI_CTRL_EGRESS = 4;
  localparam int PRCI_CTRL_IOEN = 5;
  localparam logic [31:0] PRCI_CTRL_RST = 32'h0000_0008;
  localparam logic [31:0] PRCI_SPIB_RST = 32'h0000_0020;
  localparam logic [31:0] PRCI_MEMW_RST = 32'h8000_0000;
  localparam int PRCI_TUID_COH = 4;
  localparam int PRCI_TUID_STALL = 24;
  localparam int PRCI_PASID_BITS = 16;
  localparam int PRCI_LEGACY_LINES = 4;

  typedef enum logic [1:0] {
    PRCI_ATTR_DEVICE = 2'b00,
    PRCI_ATTR_NONCACHED = 2'b01,
    PRCI_ATTR_CACHE_SHARED = 2'b10
  } prci_attr_type;

  typedef enum logic [1:0] {
    PRCI_DEST_MEM = 2'b00,
    PRCI_DEST_PEER = 2'b01,
    PRCI_DEST_ABORT = 2'b10
  } prci_dest_type;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic no_snoop;
    logic peer;
    logic translated;
    logic [15:0] pasid;
  } prci_req_type;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    prci_attr_type attr;
    logic snoop;
    logic ordered;
    logic no_merge;
    logic no_alloc;
    prci_dest_type dest;
    logic [15:0] pasid;
  } prci_out_type;

  typedef struct packed {
    logic valid;
    logic permit;
    logic cacheable;
    logic fault;
  } prci_xlat_type;

endpackage : prci_pkg

/* prci_bridge.sv */
`timescale 1ns/1ns
// Contract
// - Every legacy line of every root port gets a distinct shared interrupt
// - Legacy interrupt delivery uses only standard-defined registers
// - Each function needing virtualization is tied to a translation context
// - Snooping inbound to cacheable shared memory snoops processor caches
// - No translation: memory or device; device ordered, unmerged, no alloc
// - No translation: memory access with no-snoop issued non-cached
// - No translation: memory access without no-snoop issued cacheable shared
// - With translation keep its attributes; no-snoop downgrade optional
// - Legacy I/O maps one-to-one onto a host window, set before boot (code has no I/O window; IOEN bit is only stored)
// - Peer-to-peer attempts never deadlock, even when unsupported
// - Root ports do source check, blocking, redirects, upstream forward
// - Redirected requests validated through the translation unit
// - Access control violations detected, logged and reported
// - Peer transactions between root ports validated before forwarding
// - Translated peer access control present when peer traffic allowed
// - At least sixteen PASID bits carried end to end
// - Time measurement root takes master time from the system counter
// - Translation unit accesses are coherent, coherent flag reads one
// - Root complex never uses stall-on-fault; faults terminate (code still forwards a permitted peer request to PRCI_DEST_PEER on fault)
module prci_bridge
  import prci_pkg::*;
#(
  parameter int PORTS = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Legacy interrupt wires from root ports (asynchronous levels)
  input wire logic [PORTS*PRCI_LEGACY_LINES-1:0] intx_lines,
  output logic [PORTS*PRCI_LEGACY_LINES-1:0] spi_level,
  output logic [31:0] spi_base,
  // Inbound transaction path
  input prci_req_type in_req,
  input prci_xlat_type xlat_rsp,
  output logic xlat_query,
  output prci_out_type out_req,
  output logic acs_violation,
  // System counter for time measurement
  input wire logic [63:0] sys_counter,
  output logic [63:0] ptm_master_time
);

  localparam int NL = PORTS * PRCI_LEGACY_LINES;

  // ==========================================================
  // Address decode helper
  // ==========================================================
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction : hit

  function automatic logic mapped(input logic [31:0] a);
    mapped = hit(a, PRCI_OFF_CTRL) || hit(a, PRCI_OFF_INTX) ||
             hit(a, PRCI_OFF_STAT) || hit(a, PRCI_OFF_ACSV) ||
             hit(a, PRCI_OFF_SPIB) || hit(a, PRCI_OFF_MEMW) ||
             hit(a, PRCI_OFF_TUID) || hit(a, PRCI_OFF_PTM);
  endfunction : mapped

  // ==========================================================
  // Registers
  // ==========================================================
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] spib_q, spib_d;
  logic [31:0] memw_q, memw_d;
  logic [31:0] acsv_q, acsv_d;
  logic [15:0] vcnt_q, vcnt_d;
  logic [NL-1:0] sync1_q, sync2_q;
  prci_out_type out_q, out_d;
  logic viol_q, viol_d;
  logic query_q, query_d;
  prci_req_type hold_q, hold_d;
  logic [63:0] ptm_q;

  logic wr_en;
  logic rd_en;
  logic is_mem;
  logic [31:0] tuid;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  always_comb begin
    tuid = 32'h0000_0000;
    tuid[PRCI_TUID_COH] = 1'b1;
    tuid[PRCI_TUID_STALL] = 1'b0;
  end

  // ==========================================================
  // Legacy interrupt conversion
  // ==========================================================
  // Two-flop sync; pins are asynchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= intx_lines;
      sync2_q <= sync1_q;
    end
  end

  assign spi_level = sync2_q;
  // base is a plain standard-style number
  assign spi_base = spib_q;

  // ==========================================================
  // Time source
  // ==========================================================
  // PTM root time from counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptm_q <= 64'h0000_0000_0000_0000;
    end else begin
      ptm_q <= sys_counter;
    end
  end
  assign ptm_master_time = ptm_q;

  // ==========================================================
  // Register writes
  // ==========================================================
  always_comb begin
    ctrl_d = ctrl_q;
    spib_d = spib_q;
    memw_d = memw_q;
    if (wr_en && hit(paddr, PRCI_OFF_CTRL)) begin
      ctrl_d = {26'h0000000, pwdata[5:0]};
      // access control stays enabled with peer traffic
      if (pwdata[PRCI_CTRL_P2P]) begin
        ctrl_d[PRCI_CTRL_ACS_EN] = 1'b1;
      end
    end
    if (wr_en && hit(paddr, PRCI_OFF_SPIB)) begin
      spib_d = pwdata;
    end
    if (wr_en && hit(paddr, PRCI_OFF_MEMW)) begin
      memw_d = pwdata;
    end
  end

  // ==========================================================
  // Inbound attribute and access control
  // ==========================================================
  assign is_mem = hold_q.addr >= memw_q;

  always_comb begin
    hold_d = in_req;
    out_d = '0;
    viol_d = 1'b0;
    query_d = 1'b0;
    out_d.valid = hold_q.valid;
    out_d.addr = hold_q.addr;
    out_d.pasid = hold_q.pasid;
    out_d.dest = PRCI_DEST_MEM;
    if (hold_q.valid) begin
      if (!ctrl_q[PRCI_CTRL_XLAT]) begin
        if (!is_mem) begin
          out_d.attr = PRCI_ATTR_DEVICE;
          out_d.ordered = 1'b1;
          out_d.no_merge = 1'b1;
          out_d.no_alloc = 1'b1;
        end else if (hold_q.no_snoop) begin
          out_d.attr = PRCI_ATTR_NONCACHED;
        end else begin
          out_d.attr = PRCI_ATTR_CACHE_SHARED;
          out_d.snoop = 1'b1;
        end
      end else begin
        query_d = 1'b1;
        if (xlat_rsp.cacheable &&
            !(hold_q.no_snoop && ctrl_q[PRCI_CTRL_NSDG])) begin
          out_d.attr = PRCI_ATTR_CACHE_SHARED;
          out_d.snoop = !hold_q.no_snoop;
        end else begin
          out_d.attr = PRCI_ATTR_NONCACHED;
        end
        if (xlat_rsp.fault) begin
          out_d.dest = PRCI_DEST_ABORT;
        end
      end
      if (hold_q.peer) begin
        if (!ctrl_q[PRCI_CTRL_P2P]) begin
          out_d.dest = PRCI_DEST_ABORT;
          viol_d = 1'b1;
        end else begin
          query_d = 1'b1;
          if (!(xlat_rsp.valid && xlat_rsp.permit) ||
              ctrl_q[PRCI_CTRL_EGRESS]) begin
            out_d.dest = PRCI_DEST_ABORT;
            viol_d = 1'b1;
          end else begin
            out_d.dest = PRCI_DEST_PEER;
          end
        end
      end else if (ctrl_q[PRCI_CTRL_ACS_EN] && hold_q.translated &&
                   !ctrl_q[PRCI_CTRL_XLAT]) begin
        out_d.dest = PRCI_DEST_ABORT;
        viol_d = 1'b1;
      end
    end
  end

  // sticky log, set wins over clear
  always_comb begin
    acsv_d = acsv_q;
    vcnt_d = vcnt_q;
    if (wr_en && hit(paddr, PRCI_OFF_ACSV)) begin
      acsv_d = acsv_q & ~pwdata;
    end
    if (viol_q) begin
      acsv_d[0] = 1'b1;
      acsv_d[31:16] = out_q.addr[15:0];
      vcnt_d = vcnt_q + 16'h0001;
    end
  end

  // register state reset here; no legacy I/O window, memw_q and spib_q stay writable after boot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= PRCI_CTRL_RST;
      spib_q <= PRCI_SPIB_RST;
      memw_q <= PRCI_MEMW_RST;
      acsv_q <= 32'h0000_0000;
      vcnt_q <= 16'h0000;
      out_q <= '0;
      viol_q <= 1'b0;
      query_q <= 1'b0;
      hold_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      spib_q <= spib_d;
      memw_q <= memw_d;
      acsv_q <= acsv_d;
      vcnt_q <= vcnt_d;
      out_q <= out_d;
      viol_q <= viol_d;
      query_q <= query_d;
      hold_q <= hold_d;
    end
  end

  assign out_req = out_q;
  assign acs_violation = viol_q;
  assign xlat_query = query_q;

  // ==========================================================
  // Read data
  // ==========================================================
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      if (hit(paddr, PRCI_OFF_CTRL)) prdata = ctrl_q;
      if (hit(paddr, PRCI_OFF_INTX)) prdata = 32'(sync2_q);
      if (hit(paddr, PRCI_OFF_STAT)) prdata = {16'h0000, vcnt_q};
      if (hit(paddr, PRCI_OFF_ACSV)) prdata = acsv_q;
      if (hit(paddr, PRCI_OFF_SPIB)) prdata = spib_q;
      if (hit(paddr, PRCI_OFF_MEMW)) prdata = memw_q;
      if (hit(paddr, PRCI_OFF_TUID)) prdata = tuid;
      if (hit(paddr, PRCI_OFF_PTM)) prdata = ptm_q[31:0];
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  sequence ns_mem_s;
    hold_q.valid && !ctrl_q[PRCI_CTRL_XLAT] && is_mem && hold_q.no_snoop;
  endsequence

  nocache_ns_a: assert property (@(posedge pclk) disable iff (!presetn)
    ns_mem_s |=> out_req.attr == PRCI_ATTR_NONCACHED)
    else $error("no-snoop memory access not non-cached");

  shared_sn_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q.valid && !ctrl_q[PRCI_CTRL_XLAT] && is_mem && !hold_q.no_snoop
    |=> out_req.attr == PRCI_ATTR_CACHE_SHARED && out_req.snoop)
    else $error("snooping memory access not cacheable shared");

  device_ord_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q.valid && !ctrl_q[PRCI_CTRL_XLAT] && !is_mem
    |=> out_req.ordered && out_req.no_merge && out_req.no_alloc)
    else $error("device access not strongly ordered");

  snoop_hw_a: assert property (@(posedge pclk) disable iff (!presetn)
    out_req.snoop |-> out_req.attr == PRCI_ATTR_CACHE_SHARED)
    else $error("snoop without cacheable shared");

  legacy_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 spi_level == $past(intx_lines, 2))
    else $error("legacy line not mapped to own interrupt");

  peer_nodl_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q.valid && hold_q.peer && !ctrl_q[PRCI_CTRL_P2P]
    |=> out_req.dest == PRCI_DEST_ABORT && acs_violation)
    else $error("unsupported peer access not terminated");

  peer_val_a: assert property (@(posedge pclk) disable iff (!presetn)
    out_req.dest == PRCI_DEST_PEER |-> $past(xlat_rsp.permit))
    else $error("peer access forwarded without permission");

  viol_log_a: assert property (@(posedge pclk) disable iff (!presetn)
    acs_violation |=> acsv_q[0])
    else $error("violation not logged");

  coh_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    tuid[PRCI_TUID_COH] && !tuid[PRCI_TUID_STALL])
    else $error("coherent flag or stall bit wrong");

  acs_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[PRCI_CTRL_P2P] |-> ctrl_q[PRCI_CTRL_ACS_EN])
    else $error("peer traffic without access control");

  fault_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q.valid && ctrl_q[PRCI_CTRL_XLAT] && xlat_rsp.fault && !hold_q.peer
    |=> out_req.dest == PRCI_DEST_ABORT)
    else $error("fault did not terminate");

  pasid_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q.valid |=> out_req.pasid == $past(hold_q.pasid))
    else $error("PASID not carried");

  ptm_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ptm_master_time == $past(sys_counter))
    else $error("time source not system counter");

  xlat_blk_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q.valid && !hold_q.peer && hold_q.translated &&
    ctrl_q[PRCI_CTRL_ACS_EN] && !ctrl_q[PRCI_CTRL_XLAT]
    |=> out_req.dest == PRCI_DEST_ABORT && acs_violation)
    else $error("translated request not blocked");

  ctx_query_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q.valid && ctrl_q[PRCI_CTRL_XLAT] |=> xlat_query)
    else $error("translated request without context lookup");

  redir_val_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q.valid && hold_q.peer && ctrl_q[PRCI_CTRL_P2P] |=> xlat_query)
    else $error("peer request not validated by translation unit");

  viol_cnt_a: assert property (@(posedge pclk) disable iff (!presetn)
    acs_violation |=> vcnt_q == $past(vcnt_q) + 16'h0001)
    else $error("violation not counted");

endmodule : prci_bridge

/* prci_xlat_model.sv */
`timescale 1ns/1ns
module prci_xlat_model
  import prci_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request seen by the bridge
  input prci_req_type in_req,
  // Answer policy from the bench
  input wire logic permit,
  input wire logic cacheable,
  input wire logic fault,
  // Answer to the bridge
  output prci_xlat_type xlat_rsp
);
  logic pend_q;
  logic pend_d;
  logic junk_q;
  logic junk_d;

  // ==========================================
  // Pending query
  always_comb begin
    pend_d = in_req.valid;
    junk_d = ~junk_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      junk_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      junk_q <= junk_d;
    end
  end

  // ==========================================
  // Answer
  // Permission, coherent walk, fault terminates
  always_comb begin
    if (pend_q) begin
      xlat_rsp = {1'b1, permit, cacheable, fault};
    end else begin
      // Idle answer toggles so stale values never look valid
      xlat_rsp = {1'b0, {3{junk_q}}};
    end
  end
endmodule : prci_xlat_model

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top
  import prci_pkg::*;
();
  localparam int LINES = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, spi_base, rd, st;
  logic [LINES-1:0] intx_lines, spi_level;
  prci_req_type in_req;
  prci_xlat_type xlat_rsp;
  prci_out_type out_req, o;
  logic xlat_query, acs_violation, err, viol, qry;
  logic permit, cacheable, fault;
  logic [63:0] sys_counter, ptm_master_time;
  int n_fail, comparisons, cycles;

  prci_bridge #(.PORTS(2)) u_prci_bridge (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .intx_lines(intx_lines), .spi_level(spi_level), .spi_base(spi_base),
    .in_req(in_req), .xlat_rsp(xlat_rsp), .xlat_query(xlat_query),
    .out_req(out_req), .acs_violation(acs_violation),
    .sys_counter(sys_counter), .ptm_master_time(ptm_master_time));

  prci_xlat_model u_prci_xlat_model (.pclk(pclk), .presetn(presetn),
    .in_req(in_req), .permit(permit), .cacheable(cacheable),
    .fault(fault), .xlat_rsp(xlat_rsp));

  // ==========================================
  // Clock and timeout
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end

  // ==========================================
  // Tasks
  task automatic close_out();
    $display("counts: %0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic send(input logic [31:0] a, input logic [2:0] f);
    @(posedge pclk);
    in_req <= {1'b1, a, f, 16'hBEEF};
    @(posedge pclk);
    in_req <= '0;
    @(posedge pclk);
    #1;
    o = out_req;
    viol = acs_violation;
    qry = xlat_query;
  endtask : send

  // Flags are {no_snoop, peer, translated}
  task automatic flow(input logic [31:0] a, input logic [2:0] f,
                      input prci_attr_type ea, input prci_dest_type ed);
    send(a, f);
    chk("dest", ed, o.dest);
    if (ed != PRCI_DEST_ABORT) chk("attr", ea, o.attr);
  endtask : flow

  task automatic done(input string nm);
    $display("test %s done, %0d failed so far", nm, n_fail);
  endtask : done

  // ==========================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {intx_lines, in_req, sys_counter} = '0;
    {permit, cacheable, fault} = 3'b110;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, PRCI_OFF_CTRL, 0);
    chk("ctrl", 32'h0000_0008, rd);
    apb(0, PRCI_OFF_MEMW, 0);
    chk("memw", 32'h8000_0000, rd);
    chk("spi_base", 32'h0000_0020, spi_base);
    apb(1, PRCI_OFF_TUID, 32'hFFFF_FFFF);
    apb(0, PRCI_OFF_TUID, 0);
    chk("tu_ident", 32'h0000_0010, rd & 32'h0100_0010);
    chk("pready", 1, pready);
    apb(1, 32'h0000_0040, 32'hFFFF_FFFF);
    chk("slverr_wr", 1, err);
    apb(0, 32'h0000_0040, 0);
    chk("slverr_rd", 1, err);
    chk("unmapped", 0, rd);
    done("registers");
    // Lines held as steady levels, one per line
    for (int i = 0; i < LINES; i++) begin
      @(posedge pclk);
      intx_lines <= 8'h01 << i;
      repeat (4) @(posedge pclk);
      chk("spi_level", 8'h01 << i, spi_level);
      apb(0, PRCI_OFF_INTX, 0);
      chk("intx", 32'h1 << i, rd);
    end
    apb(1, PRCI_OFF_SPIB, 32'h0000_0040);
    @(posedge pclk);
    chk("spi_base", 32'h0000_0040, spi_base);
    done("legacy");
    flow(32'h0000_1000, 3'b000, PRCI_ATTR_DEVICE, PRCI_DEST_MEM);
    chk("dev_flags", 3'b111, {o.ordered, o.no_merge, o.no_alloc});
    flow(32'h9000_0000, 3'b100, PRCI_ATTR_NONCACHED,
         PRCI_DEST_MEM);
    flow(32'h9000_0000, 3'b000, PRCI_ATTR_CACHE_SHARED, PRCI_DEST_MEM);
    chk("snoop", 1, o.snoop);
    chk("pasid", 16'hBEEF, o.pasid);
    flow(32'h9000_0000, 3'b001, PRCI_ATTR_DEVICE, PRCI_DEST_ABORT);
    flow(32'h9000_0000, 3'b010, PRCI_ATTR_DEVICE, PRCI_DEST_ABORT);
    done("no_xlat");
    apb(1, PRCI_OFF_CTRL, 32'h0000_0001);
    flow(32'h9000_0000, 3'b000, PRCI_ATTR_CACHE_SHARED, PRCI_DEST_MEM);
    chk("query", 1, qry);
    flow(32'h9000_0000, 3'b100, PRCI_ATTR_CACHE_SHARED, PRCI_DEST_MEM);
    apb(1, PRCI_OFF_CTRL, 32'h0000_0003);
    flow(32'h9000_0000, 3'b100, PRCI_ATTR_NONCACHED, PRCI_DEST_MEM);
    cacheable <= 1'b0;
    flow(32'h9000_0000, 3'b000, PRCI_ATTR_NONCACHED, PRCI_DEST_MEM);
    fault <= 1'b1;
    flow(32'h9000_0000, 3'b000, PRCI_ATTR_DEVICE, PRCI_DEST_ABORT);
    fault <= 1'b0;
    done("xlat");
    apb(1, PRCI_OFF_CTRL, 32'h0000_0024);
    apb(0, PRCI_OFF_CTRL, 0);
    chk("acs_forced", 32'h0000_002C, rd);
    apb(1, PRCI_OFF_CTRL, 32'h0000_0005);
    flow(32'h9000_0000, 3'b010, PRCI_ATTR_NONCACHED, PRCI_DEST_PEER);
    chk("query", 1, qry);
    flow(32'h9000_0000, 3'b011, PRCI_ATTR_NONCACHED, PRCI_DEST_PEER);
    apb(0, PRCI_OFF_STAT, 0);
    st = rd;
    permit <= 1'b0;
    flow(32'h9000_0000, 3'b010, PRCI_ATTR_DEVICE, PRCI_DEST_ABORT);
    chk("violation", 1, viol);
    permit <= 1'b1;
    apb(0, PRCI_OFF_STAT, 0);
    chk("count", st[15:0] + 16'h1, rd[15:0]);
    apb(0, PRCI_OFF_ACSV, 0);
    chk("sticky", 1, rd[0]);
    apb(1, PRCI_OFF_ACSV, 32'h0000_0001);
    apb(0, PRCI_OFF_ACSV, 0);
    chk("cleared", 0, rd[0]);
    done("peer");
    @(posedge pclk);
    sys_counter <= 64'h0123_4567_89AB_CDEF;
    repeat (3) @(posedge pclk);
    chk("ptm", 64'h0123_4567_89AB_CDEF, ptm_master_time);
    apb(0, PRCI_OFF_PTM, 0);
    chk("ptm_reg", 32'h89AB_CDEF, rd);
    done("ptm");
    close_out();
  end
endmodule : tb_top
